// ==== verilog/pcw_pkg.sv ====
package pcw_pkg;
	// I/O ports of the indexed register window
	localparam logic [9:0] PCW_INDEX_PORT    = 10'h022;
	localparam logic [9:0] PCW_DATA_PORT     = 10'h023;
	// Register index and reset value
	localparam logic [7:0] PCW_CFG_INDEX     = 8'h01;
	localparam logic [7:0] PCW_CFG_RESET     = 8'hc0;
	localparam logic [7:0] PCW_INDEX_RESET   = 8'h00;
	localparam logic [7:0] PCW_UNMAPPED_READ = 8'h00;
	// Field positions in peripheral_timing_config
	localparam int         PCW_REG_WS_LO     = 6;
	localparam int         PCW_DMA16_WS_LO   = 4;
	localparam int         PCW_DMA8_WS_LO    = 2;
	localparam int         PCW_EARLY_RD_BIT  = 1;
	localparam int         PCW_CLK_FULL_BIT  = 0;
	localparam int         PCW_WS_W          = 2;
	// Wait counter: code 0 gives one wait state
	localparam int         PCW_CNT_W         = 3;
	localparam logic [2:0] PCW_WS_BASE       = 3'h1;
	localparam logic [2:0] PCW_CNT_ZERO      = 3'h0;
	// Pin synchroniser lanes
	localparam int         PCW_PIN_N         = 3;
	localparam int         PCW_PIN_RD        = 0;
	localparam int         PCW_PIN_WR        = 1;
	localparam int         PCW_PIN_RDY       = 2;
	localparam logic [2:0] PCW_PIN_IDLE      = 3'h7;

	typedef enum logic [1:0] {
		PCW_IO_IDLE = 2'b00,
		PCW_IO_WAIT = 2'b01,
		PCW_IO_HOLD = 2'b10
	} pcw_io_state_t;
endpackage : pcw_pkg

// ==== verilog/pcw_wait_if.sv ====
`timescale 1ns/1ps
interface pcw_wait_if;
	logic       start;
	logic       tick;
	logic       ext_ready;
	logic [1:0] code;
	logic       busy;
	logic       done;

	modport ctrl (output start, output tick, output ext_ready, output code,
		input busy, input done);
	modport gen (input start, input tick, input ext_ready, input code,
		output busy, output done);
endinterface : pcw_wait_if

// ==== verilog/pcw_wait_gen.sv ====
`timescale 1ns/1ps
module pcw_wait_gen
	import pcw_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Wait request and answer
	pcw_wait_if.gen  w
);
	logic [PCW_CNT_W-1:0] cnt_ff;
	logic                 busy_ff;
	logic                 done_ff;

	assign w.busy = busy_ff;
	assign w.done = done_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_ff  <= PCW_CNT_ZERO;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (w.start) begin
				busy_ff <= 1'b1;
				// The tick that finds zero is the last wait, so code 0 gives one
				cnt_ff  <= {1'b0, w.code};
			end else if (busy_ff && w.tick) begin
				if (cnt_ff != PCW_CNT_ZERO) begin
					cnt_ff <= cnt_ff - PCW_WS_BASE;
				end else if (w.ext_ready) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
		end
	end
endmodule : pcw_wait_gen

// ==== verilog/pcw_timing_cfg.sv ====
`timescale 1ns/1ps
module pcw_timing_cfg
	import pcw_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// ISA I/O cycle from the host
	input  wire logic [9:0] io_addr,
	input  wire logic       io_rd_n,
	input  wire logic       io_wr_n,
	input  wire logic [7:0] io_data_in,
	output logic      [7:0] io_data_out,
	output logic            io_data_oe,
	// Open-drain bus ready line
	input  wire logic       iochrdy_in,
	output logic            iochrdy_out,
	output logic            iochrdy_oe,
	// DMA cycle control from the DMA subsystems
	input  wire logic       dma_start,
	input  wire logic       dma_16bit,
	input  wire logic       smemr_n,
	output logic            dma_busy,
	output logic            dma_done,
	output logic            dma_mem_read_strobe_n,
	// DMA clock enable and configuration view
	output logic            dma_clk_en,
	output logic            dma_clk_full,
	output logic      [7:0] timing_cfg
);
	import pcw_pkg::*;

	pcw_wait_if reg_w ();
	pcw_wait_if dma_w ();

	pcw_wait_gen u_reg_wait (
		.clock (clock),
		.rst   (rst),
		.w     (reg_w.gen)
	);

	pcw_wait_gen u_dma_wait (
		.clock (clock),
		.rst   (rst),
		.w     (dma_w.gen)
	);

	// Pin synchronisers, strobes and ready
	logic [PCW_PIN_N-1:0] pin_raw;
	logic [PCW_PIN_N-1:0] sync1_ff;
	logic [PCW_PIN_N-1:0] sync2_ff;
	logic [PCW_PIN_N-1:0] sync3_ff;
	logic [PCW_PIN_N-1:0] stable_ff;
	logic [PCW_PIN_N-1:0] stable_d_ff;

	assign pin_raw = {iochrdy_in, io_wr_n, io_rd_n};

	genvar gi;
	generate
		for (gi = 0; gi < PCW_PIN_N; gi++) begin : g_sync
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					sync1_ff[gi]    <= PCW_PIN_IDLE[gi];
					sync2_ff[gi]    <= PCW_PIN_IDLE[gi];
					sync3_ff[gi]    <= PCW_PIN_IDLE[gi];
					stable_ff[gi]   <= PCW_PIN_IDLE[gi];
					stable_d_ff[gi] <= PCW_PIN_IDLE[gi];
				end else begin
					sync1_ff[gi]    <= pin_raw[gi];
					sync2_ff[gi]    <= sync1_ff[gi];
					sync3_ff[gi]    <= sync2_ff[gi];
					stable_d_ff[gi] <= stable_ff[gi];
					// Glitch shorter than a cycle never reaches the stable view
					if (sync2_ff[gi] == sync3_ff[gi]) begin
						stable_ff[gi] <= sync3_ff[gi];
					end
				end
			end
		end
	endgenerate

	logic rd_fall;
	logic wr_fall;
	logic strobes_idle;
	logic hit_index;
	logic hit_data;
	logic bus_ready;

	assign rd_fall      = stable_d_ff[PCW_PIN_RD] && !stable_ff[PCW_PIN_RD];
	assign wr_fall      = stable_d_ff[PCW_PIN_WR] && !stable_ff[PCW_PIN_WR];
	assign strobes_idle = stable_ff[PCW_PIN_RD] && stable_ff[PCW_PIN_WR];
	assign hit_index    = (io_addr == PCW_INDEX_PORT);
	assign hit_data     = (io_addr == PCW_DATA_PORT);
	assign bus_ready    = stable_ff[PCW_PIN_RDY];

	// Indexed register file
	logic [7:0]    index_ff;
	logic [7:0]    cfg_ff;
	logic [7:0]    data_out_ff;
	logic          data_oe_ff;
	logic          rdy_oe_ff;
	logic          reg_start_ff;
	pcw_io_state_t io_state_ff;
	logic [7:0]    rd_value;

	always_comb begin
		rd_value = PCW_UNMAPPED_READ;
		if (hit_index) begin
			rd_value = index_ff;
		end else if (index_ff == PCW_CFG_INDEX) begin
			rd_value = cfg_ff;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			index_ff     <= PCW_INDEX_RESET;
			cfg_ff       <= PCW_CFG_RESET;
			data_out_ff  <= PCW_UNMAPPED_READ;
			data_oe_ff   <= 1'b0;
			rdy_oe_ff    <= 1'b0;
			reg_start_ff <= 1'b0;
			io_state_ff  <= PCW_IO_IDLE;
		end else begin
			reg_start_ff <= 1'b0;
			case (io_state_ff)
				PCW_IO_IDLE: begin
					if ((rd_fall || wr_fall) && (hit_index || hit_data)) begin
						reg_start_ff <= 1'b1;
						rdy_oe_ff    <= 1'b1;
						io_state_ff  <= PCW_IO_WAIT;
						if (wr_fall && hit_index) begin
							index_ff <= io_data_in;
						end
						if (wr_fall && hit_data && index_ff == PCW_CFG_INDEX) begin
							cfg_ff <= io_data_in;
						end
						if (rd_fall) begin
							data_out_ff <= rd_value;
							data_oe_ff  <= 1'b1;
						end
					end
				end
				PCW_IO_WAIT: begin
					if (reg_w.done) begin
						rdy_oe_ff   <= 1'b0;
						io_state_ff <= PCW_IO_HOLD;
					end
				end
				PCW_IO_HOLD: begin
					// Keep driving read data until the host drops its strobe
					if (strobes_idle) begin
						data_oe_ff  <= 1'b0;
						io_state_ff <= PCW_IO_IDLE;
					end
				end
				default: begin
					rdy_oe_ff   <= 1'b0;
					data_oe_ff  <= 1'b0;
					io_state_ff <= PCW_IO_IDLE;
				end
			endcase
		end
	end

	// Register waits run every system clock and ignore the ready line
	assign reg_w.start     = reg_start_ff;
	assign reg_w.tick      = 1'b1;
	assign reg_w.ext_ready = 1'b1;
	assign reg_w.code      = cfg_ff[PCW_REG_WS_LO +: PCW_WS_W];

	// DMA clock divider with glitch-free selection
	logic div_ff;
	logic full_sel_ff;
	logic tick_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_ff      <= 1'b0;
			full_sel_ff <= 1'b0;
			tick_ff     <= 1'b0;
		end else begin
			div_ff <= ~div_ff;
			// Leave half rate only at the end of a whole halved period, leave full rate at once, so no short pulse
			if (full_sel_ff != cfg_ff[PCW_CLK_FULL_BIT] && (full_sel_ff || div_ff)) begin
				full_sel_ff <= cfg_ff[PCW_CLK_FULL_BIT];
				div_ff      <= 1'b0;
				tick_ff     <= 1'b0;
			end else begin
				tick_ff <= full_sel_ff | div_ff;
			end
		end
	end

	// DMA cycle wait states
	logic dma_start_ff;
	logic dma_16_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dma_start_ff <= 1'b0;
			dma_16_ff    <= 1'b0;
		end else begin
			dma_start_ff <= dma_start && !dma_w.busy;
			if (dma_start && !dma_w.busy) begin
				dma_16_ff <= dma_16bit;
			end
		end
	end

	assign dma_w.start     = dma_start_ff;
	assign dma_w.tick      = tick_ff;
	assign dma_w.ext_ready = bus_ready;
	assign dma_w.code      = dma_16_ff ? cfg_ff[PCW_DMA16_WS_LO +: PCW_WS_W]
		: cfg_ff[PCW_DMA8_WS_LO +: PCW_WS_W];

	// DMA memory-read strobe timing
	logic smemr_late_n_ff;
	logic strobe_n_ff;
	logic dma_busy_ff;
	logic dma_done_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			smemr_late_n_ff <= 1'b1;
			strobe_n_ff     <= 1'b1;
			dma_busy_ff     <= 1'b0;
			dma_done_ff     <= 1'b0;
		end else begin
			dma_busy_ff <= dma_w.busy || dma_start_ff;
			dma_done_ff <= dma_w.done;
			// Late copy follows on DMA clock; release is never delayed
			if (smemr_n) begin
				smemr_late_n_ff <= 1'b1;
			end else if (tick_ff) begin
				smemr_late_n_ff <= 1'b0;
			end
			if (cfg_ff[PCW_EARLY_RD_BIT]) begin
				strobe_n_ff <= smemr_n;
			end else begin
				strobe_n_ff <= smemr_n | smemr_late_n_ff;
			end
		end
	end

	assign io_data_out           = data_out_ff;
	assign io_data_oe            = data_oe_ff;
	assign iochrdy_out           = 1'b0;
	assign iochrdy_oe            = rdy_oe_ff;
	assign dma_busy              = dma_busy_ff;
	assign dma_done              = dma_done_ff;
	assign dma_mem_read_strobe_n = strobe_n_ff;
	assign dma_clk_en            = tick_ff;
	assign dma_clk_full          = full_sel_ff;
	assign timing_cfg            = cfg_ff;
endmodule : pcw_timing_cfg

// ==== test/pcw_timing_cfg_properties.sv ====
`timescale 1ns/1ps
module pcw_timing_cfg_properties (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// Observed ports
	input wire logic       iochrdy_in,
	input wire logic       iochrdy_oe,
	input wire logic       io_data_oe,
	input wire logic       dma_busy,
	input wire logic       dma_done,
	input wire logic       smemr_n,
	input wire logic       dma_mem_read_strobe_n,
	input wire logic       dma_clk_en,
	input wire logic       dma_clk_full,
	input wire logic [7:0] timing_cfg
);
	logic [3:0] pull_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Pull length in system clocks, whatever the DMA clock does
	always_ff @(posedge clock or posedge rst) begin
		if (rst) pull_ff <= 4'h0;
		else pull_ff <= iochrdy_oe ? pull_ff + 4'h1 : 4'h0;
	end
	sequence s_starve; !iochrdy_in [*6]; endsequence
	sequence s_end; dma_busy ##1 !dma_busy; endsequence
	sequence s_late; dma_mem_read_strobe_n ##[1:3] !dma_mem_read_strobe_n; endsequence
	property p_rst; $fell(rst) |-> timing_cfg == 8'hc0 && !iochrdy_oe && !dma_busy; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_wait; $fell(iochrdy_oe) && io_data_oe |-> pull_ff == 4'(timing_cfg[7:6]) + 4'h3;
	endproperty
	a_wait: assert property (p_wait) else $error("wait length");
	property p_done; s_end |-> dma_done; endproperty
	a_done: assert property (p_done) else $error("done order");
	property p_stall; s_starve |-> !dma_done; endproperty
	a_stall: assert property (p_stall) else $error("done while not ready");
	property p_early; timing_cfg[1] && $stable(timing_cfg) |=>
		dma_mem_read_strobe_n == $past(smemr_n); endproperty
	a_early: assert property (p_early) else $error("early strobe");
	property p_late; !timing_cfg[1] && $fell(smemr_n) |=> s_late; endproperty
	a_late: assert property (p_late) else $error("late strobe");
	property p_half; !dma_clk_full && dma_clk_en |=> !dma_clk_en; endproperty
	a_half: assert property (p_half) else $error("half rate");
	property p_sel; timing_cfg[0] != dma_clk_full |-> ##[1:3] timing_cfg[0] == dma_clk_full;
	endproperty
	a_sel: assert property (p_sel) else $error("clock select");
endmodule : pcw_timing_cfg_properties
bind pcw_timing_cfg pcw_timing_cfg_properties pcw_timing_cfg_properties_inst (.*);

// ==== test/pcw_host_model.sv ====
`timescale 1ns/1ps
module pcw_host_model (
	// Clock
	input wire logic       clock,
	// I/O cycle to the device
	output logic     [9:0] io_addr,
	output logic           io_rd_n,
	output logic           io_wr_n,
	output logic     [7:0] io_data_in,
	// Answer from the device
	input wire logic       iochrdy_in,
	input wire logic [7:0] io_data_out
);
	initial begin
		io_addr = 10'h3dd;
		io_rd_n = 1'b1;
		io_wr_n = 1'b1;
		io_data_in = 8'hff;
	end
	// Released lines show inverted values so stale data cannot pass
	task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		n = 0;
		io_addr <= a;
		io_data_in <= d;
		io_rd_n <= w;
		io_wr_n <= !w;
		do @(posedge clock); while (iochrdy_in && ++n < 40);
		do @(posedge clock); while (!iochrdy_in && ++n < 40);
		if (n >= 40) pcw_timing_cfg_tb_top.hang();
		r = io_data_out;
		io_rd_n <= 1'b1;
		io_wr_n <= 1'b1;
		io_addr <= ~a;
		io_data_in <= ~d;
		repeat (10) @(posedge clock);
	endtask : io
endmodule : pcw_host_model

// ==== test/pcw_timing_cfg_tb_top.sv ====
`timescale 1ns/1ps
module pcw_timing_cfg_tb_top;
	import pcw_pkg::*;
	typedef struct packed {logic w; logic p; logic [7:0] d; logic [7:0] e;} pcw_row_t;
	logic       clock, rst, io_rd_n, io_wr_n, io_data_oe, iochrdy_out, iochrdy_oe;
	logic       dma_start, dma_16bit, smemr_n, dma_busy, dma_done, dma_mem_read_strobe_n;
	logic       dma_clk_en, dma_clk_full, ext_low;
	logic [9:0] io_addr;
	logic [7:0] io_data_in, io_data_out, timing_cfg, q;
	int         error_cnt, n_checks;
	// Open-drain ready with pull-up
	wire        iochrdy_in = !((iochrdy_oe && !iochrdy_out) || ext_low);
	pcw_row_t   rows [10] = '{'{0, 1, 8'h00, 8'h00}, '{1, 0, 8'h01, 8'hc0},
		'{0, 1, 8'h00, 8'hc0}, '{1, 1, 8'h00, 8'h00}, '{0, 1, 8'h00, 8'h00},
		'{0, 0, 8'h00, 8'h01}, '{1, 0, 8'h05, 8'h00}, '{1, 1, 8'haa, 8'h00},
		'{1, 0, 8'h01, 8'h00}, '{0, 1, 8'h00, 8'h00}};
	logic [7:0] cfgs [3] = '{8'h39, 8'h96, 8'h24};

	pcw_timing_cfg pcw_timing_cfg_inst (.*);
	pcw_host_model pcw_host_model_inst (.*);

	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic conclude();
		if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	task automatic hang();
		chk("wait_bound", 8'h01, 8'h00);
		conclude();
	endtask : hang
	// A stalled cycle must run well past its programmed ticks
	task automatic dma(input logic w16, input logic [1:0] c, input logic slow);
		int n;
		int t;
		n = 0;
		t = 0;
		dma_start <= 1'b1;
		dma_16bit <= w16;
		smemr_n <= 1'b0;
		ext_low <= slow;
		@(posedge clock);
		dma_start <= 1'b0;
		dma_16bit <= !w16;
		do begin
			@(posedge clock);
			t += int'(dma_clk_en && dma_busy);
			if (n == 24) ext_low <= 1'b0;
		end while (!dma_done && ++n < 300);
		if (n >= 300) hang();
		chk("dma_ticks", 8'(t > c && t <= c + 3), 8'(!slow));
		smemr_n <= 1'b1;
		@(posedge clock);
	endtask : dma

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		rst = 1'b1;
		dma_start = 1'b0;
		dma_16bit = 1'b0;
		smemr_n = 1'b1;
		ext_low = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		foreach (rows[i]) begin
			pcw_host_model_inst.io(rows[i].w, rows[i].p ? PCW_DATA_PORT : PCW_INDEX_PORT,
				rows[i].d, q);
			chk("io", rows[i].w ? timing_cfg : q, rows[i].e);
		end
		foreach (cfgs[k]) begin
			pcw_host_model_inst.io(1'b1, PCW_DATA_PORT, cfgs[k], q);
			for (int j = 0; j < 3; j++) dma(j != 1, j != 1 ? cfgs[k][5:4] : cfgs[k][3:2], j == 2);
		end
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk("cfg_reset", timing_cfg, 8'hc0);
		chk("rdy_drive", {7'h00, iochrdy_out}, 8'h00);
		conclude();
	end
endmodule : pcw_timing_cfg_tb_top
